//--- rtl/dao_output.sv
// Digital output side of a dual 10-bit sampling converter.
`timescale 1ns/1ps
// Behaviour
// - Both channels are sampled on each rising edge of the sample clock.
// - A high sleep input puts its channel in reduced power; low runs it.
// - Style select high gives double-data-rate pairs; low gives parallel words.
// - Double-data-rate mode drives ten pairs interleaving channel A and B.
// - Channel A is ready at strobe rising, channel B at strobe falling.
// - Shared range flag follows the same interleaved A and B timing.
// - A range flag is high while its channel input is out of range.
// - Parallel mode puts channel A on its own word, bit 0 least significant.
// - Parallel mode puts channel B on a separate word, bit 0 least significant.
// - Channel A strobe runs at sample rate; A data valid on its rising edge.
// - Channel B strobe runs at sample rate; B data valid on its rising edge.
// - Parallel mode gives each channel a dedicated range flag output.
// - One selection input chooses both data format and duty correction.
// - Bands: twos+dcc, offset, twos, offset+dcc from lowest to highest.
module dao_output
  import dao_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic                  sample_clk,
  input  wire logic [DAO_WORD_W-1:0] conv_a_raw,
  input  wire logic [DAO_WORD_W-1:0] conv_b_raw,
  input  wire logic                  conv_a_over,
  input  wire logic                  conv_b_over,
  input  wire logic                  sleep_chan_a,
  input  wire logic                  sleep_chan_b,
  input  wire logic                  output_style_select,
  input  wire logic [1:0]            format_and_duty_select,
  input  wire logic [DAO_ADDR_W-1:0] bus_addr,
  input  wire logic [31:0]           bus_wdata,
  input  wire logic                  bus_wr,
  input  wire logic                  bus_rd,
  output logic      [31:0]           bus_rdata,
  output logic      [DAO_WORD_W-1:0] interleaved_bit_pairs,
  output logic                       range_flag_pair,
  output logic                       ddr_capture_strobe,
  output logic      [DAO_WORD_W-1:0] chan_a_word,
  output logic      [DAO_WORD_W-1:0] chan_b_word,
  output logic                       chan_a_strobe,
  output logic                       chan_b_strobe,
  output logic                       range_flag_a,
  output logic                       range_flag_b,
  output logic                       duty_correction,
  output logic                       sleep_a_active,
  output logic                       sleep_b_active,
  output logic                       irq
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  dao_pins_t pins_raw;
  dao_pins_t pins_s;
  logic      sclk_s;
  logic      sclk_d_reg;

  assign pins_raw = '{band:    format_and_duty_select,
                      style:   output_style_select,
                      sleep_b: sleep_chan_b,
                      sleep_a: sleep_chan_a};

  dao_sync #(.W(DAO_PINS_W)) u_pin_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .d      (pins_raw),
    .q      (pins_s)
  );

  dao_sync #(.W(1)) u_sclk_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .d      (sample_clk),
    .q      (sclk_s)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sclk_d_reg <= 1'b0;
    end else if (ce) begin
      sclk_d_reg <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and mode decode
  // ----------------------------------------------------------------
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;

  wire style_ddr = (pins_s.style == DAO_STYLE_DDR);

  wire fmt_twos = (pins_s.band == DAO_BAND_TWOS_DCC) |
                  (pins_s.band == DAO_BAND_TWOS_NODCC);
  wire dcc_on   = (pins_s.band == DAO_BAND_TWOS_DCC) |
                  (pins_s.band == DAO_BAND_OFFS_DCC);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic                 outputs_on_reg;
  logic [DAO_IRQ_W-1:0] irq_st_reg;
  logic [DAO_IRQ_W-1:0] irq_st_next;
  logic [DAO_IRQ_W-1:0] irq_en_reg;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;
  logic [DAO_IRQ_W-1:0] irq_event;

  wire sel_ctrl    = (bus_addr == DAO_OFF_CTRL);
  wire sel_state   = (bus_addr == DAO_OFF_STATE);
  wire sel_irq_st  = (bus_addr == DAO_OFF_IRQ_ST);
  wire sel_irq_en  = (bus_addr == DAO_OFF_IRQ_EN);
  wire sel_irq_clr = (bus_addr == DAO_OFF_IRQ_CLR);

  wire [DAO_IRQ_W-1:0] irq_clr =
    (bus_wr && sel_irq_clr) ? bus_wdata[DAO_IRQ_W-1:0] : '0;

  // A new event wins over a clear in the same cycle.
  assign irq_st_next = (irq_st_reg & ~irq_clr) | irq_event;

  wire [31:0] state_word = {24'h000000, 1'b0, fmt_twos, dcc_on,
                            pins_s.band, style_ddr,
                            pins_s.sleep_b, pins_s.sleep_a};

  assign rdata_next =
    !bus_rd    ? 32'h00000000 :
    sel_ctrl   ? {31'h00000000, outputs_on_reg} :
    sel_state  ? state_word :
    sel_irq_st ? {30'h00000000, irq_st_reg} :
    sel_irq_en ? {30'h00000000, irq_en_reg} :
                 32'h00000000;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      outputs_on_reg <= DAO_CTRL_RST;
      irq_en_reg     <= DAO_IRQ_EN_RST;
      irq_st_reg     <= '0;
      rdata_reg      <= 32'h00000000;
    end else if (ce) begin
      if (bus_wr && sel_ctrl) begin
        outputs_on_reg <= bus_wdata[0];
      end
      if (bus_wr && sel_irq_en) begin
        irq_en_reg <= bus_wdata[DAO_IRQ_W-1:0];
      end
      irq_st_reg <= irq_st_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign irq       = |(irq_st_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // Sample capture and formatting
  // ----------------------------------------------------------------
  dao_sample_t conv_a;
  dao_sample_t conv_b;
  dao_sample_t cap_a_reg;
  dao_sample_t cap_b_reg;
  dao_sample_t cap_a_next;
  dao_sample_t cap_b_next;

  assign conv_a = '{over: conv_a_over, word: conv_a_raw};
  assign conv_b = '{over: conv_b_over, word: conv_b_raw};

  // Converts an offset binary result to the selected format. A sleeping
  // channel reads as all zero with its range flag low.
  function automatic dao_sample_t dao_fmt(input dao_sample_t s,
                                          input logic        sleep,
                                          input logic        twos);
    dao_sample_t r;
    r = s;
    if (twos) begin
      r.word[DAO_MSB] = ~s.word[DAO_MSB];
    end
    if (sleep) begin
      r = DAO_SAMPLE_RST;
    end
    return r;
  endfunction : dao_fmt

  assign cap_a_next = dao_fmt(conv_a, pins_s.sleep_a, fmt_twos);
  assign cap_b_next = dao_fmt(conv_b, pins_s.sleep_b, fmt_twos);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cap_a_reg <= DAO_SAMPLE_RST;
      cap_b_reg <= DAO_SAMPLE_RST;
    end else if (ce && sclk_rise) begin
      cap_a_reg <= cap_a_next;
      cap_b_reg <= cap_b_next;
    end
  end

  // Range events are raised once per sample while a channel is over range.
  assign irq_event[DAO_IRQ_OVR_A] = ce & sclk_rise & cap_a_next.over;
  assign irq_event[DAO_IRQ_OVR_B] = ce & sclk_rise & cap_b_next.over;

  // ----------------------------------------------------------------
  // Output phase tracking
  // ----------------------------------------------------------------
  dao_phase_t phase_reg;
  dao_phase_t phase_next;

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      DAO_IDLE: begin
        if (sclk_rise) begin
          phase_next = DAO_SLOT_A;
        end
      end
      DAO_SLOT_A: begin
        if (sclk_fall) begin
          phase_next = DAO_SLOT_B;
        end
      end
      DAO_SLOT_B: begin
        if (sclk_rise) begin
          phase_next = DAO_SLOT_A;
        end
      end
      default: begin
        phase_next = DAO_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      phase_reg <= DAO_IDLE;
    end else if (ce) begin
      phase_reg <= phase_next;
    end
  end

  wire running = (phase_reg != DAO_IDLE) & outputs_on_reg;

  // ----------------------------------------------------------------
  // Strobe generation
  // ----------------------------------------------------------------
  logic [DAO_STROBE_LAG-1:0] lag_reg;

  // Delaying the sample clock gives data setup ahead of each edge.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lag_reg <= '0;
    end else if (ce) begin
      lag_reg <= {lag_reg[DAO_STROBE_LAG-2:0], sclk_s};
    end
  end

  wire strobe_base = lag_reg[DAO_STROBE_LAG-1] & running;

  assign ddr_capture_strobe = strobe_base & style_ddr;
  assign chan_a_strobe      = strobe_base & ~style_ddr;
  assign chan_b_strobe      = strobe_base & ~style_ddr;

  // ----------------------------------------------------------------
  // Output words
  // ----------------------------------------------------------------
  dao_sample_t pair_reg;
  dao_sample_t pair_next;
  dao_sample_t par_a_reg;
  dao_sample_t par_b_reg;
  dao_sample_t par_a_next;
  dao_sample_t par_b_next;
  dao_sample_t slot_b_reg;

  wire ddr_on = outputs_on_reg & style_ddr;
  wire par_on = outputs_on_reg & ~style_ddr;

  // interleave A then B on one bus
  // flag rides in the same slot
  assign pair_next = !ddr_on   ? DAO_SAMPLE_RST :
                     sclk_rise ? cap_a_reg :
                     sclk_fall ? slot_b_reg :
                                 pair_reg;

  assign par_a_next = !par_on   ? DAO_SAMPLE_RST :
                      sclk_rise ? cap_a_reg :
                                  par_a_reg;
  assign par_b_next = !par_on   ? DAO_SAMPLE_RST :
                      sclk_rise ? cap_b_reg :
                                  par_b_reg;

  // one sample per period, one period of latency, except one and a half periods for B in pair style
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pair_reg   <= DAO_SAMPLE_RST;
      par_a_reg  <= DAO_SAMPLE_RST;
      par_b_reg  <= DAO_SAMPLE_RST;
      slot_b_reg <= DAO_SAMPLE_RST;
    end else if (ce) begin
      pair_reg  <= pair_next;
      par_a_reg <= par_a_next;
      par_b_reg <= par_b_next;
      if (sclk_rise) begin
        slot_b_reg <= cap_b_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  logic dcc_reg;
  logic sleep_a_reg;
  logic sleep_b_reg;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dcc_reg     <= 1'b0;
      sleep_a_reg <= 1'b0;
      sleep_b_reg <= 1'b0;
    end else if (ce) begin
      dcc_reg     <= dcc_on;
      sleep_a_reg <= pins_s.sleep_a;
      sleep_b_reg <= pins_s.sleep_b;
    end
  end

  assign interleaved_bit_pairs = pair_reg.word;
  assign range_flag_pair       = pair_reg.over;
  assign chan_a_word           = par_a_reg.word;
  assign chan_b_word           = par_b_reg.word;
  assign range_flag_a          = par_a_reg.over;
  assign range_flag_b          = par_b_reg.over;
  assign duty_correction       = dcc_reg;
  assign sleep_a_active        = sleep_a_reg;
  assign sleep_b_active        = sleep_b_reg;

endmodule : dao_output

//--- rtl/dao_pkg.sv
// Package with constants, types and register map of the dual converter output.
package dao_pkg;

  // ----------------------------------------------------------------
  // Sample word layout
  // ----------------------------------------------------------------
  localparam int DAO_WORD_W = 10;
  localparam int DAO_MSB    = 9;

  typedef struct packed {
    logic                  over;
    logic [DAO_WORD_W-1:0] word;
  } dao_sample_t;

  localparam dao_sample_t DAO_SAMPLE_RST = '{over: 1'b0, word: 10'h000};

  // ----------------------------------------------------------------
  // Static pin group, sampled through the synchroniser
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] band;
    logic       style;
    logic       sleep_b;
    logic       sleep_a;
  } dao_pins_t;

  localparam int DAO_PINS_W = 5;

  // Level bands of the format and duty selection input.
  localparam logic [1:0] DAO_BAND_TWOS_DCC   = 2'h0;
  localparam logic [1:0] DAO_BAND_OFFS_NODCC = 2'h1;
  localparam logic [1:0] DAO_BAND_TWOS_NODCC = 2'h2;
  localparam logic [1:0] DAO_BAND_OFFS_DCC   = 2'h3;

  // Output style select level meaning the double-data-rate pairs.
  localparam logic DAO_STYLE_DDR = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Cycles between a synchronised sample clock edge and the matching strobe edge.
  localparam int DAO_STROBE_LAG = 2;

  // ----------------------------------------------------------------
  // Output phase states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DAO_IDLE,
    DAO_SLOT_A,
    DAO_SLOT_B
  } dao_phase_t;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         DAO_ADDR_W      = 8;
  localparam logic [7:0] DAO_OFF_CTRL    = 8'h00;
  localparam logic [7:0] DAO_OFF_STATE   = 8'h04;
  localparam logic [7:0] DAO_OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0] DAO_OFF_IRQ_EN  = 8'h0c;
  localparam logic [7:0] DAO_OFF_IRQ_CLR = 8'h10;

  localparam int         DAO_IRQ_W       = 2;
  localparam int         DAO_IRQ_OVR_A   = 0;
  localparam int         DAO_IRQ_OVR_B   = 1;
  localparam logic [1:0] DAO_IRQ_EN_RST  = 2'h0;
  localparam logic       DAO_CTRL_RST    = 1'b1;

endpackage : dao_pkg

//--- rtl/dao_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module dao_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // The first stage is read only by the second.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule : dao_sync

//--- test/dao_capture.sv
// Capture logic model that receives samples from the converter outputs.
`timescale 1ns/1ps
module dao_capture
  import dao_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire logic [DAO_WORD_W-1:0] interleaved_bit_pairs,
  input wire logic                  range_flag_pair,
  input wire logic                  ddr_capture_strobe,
  input wire logic [DAO_WORD_W-1:0] chan_a_word,
  input wire logic [DAO_WORD_W-1:0] chan_b_word,
  input wire logic                  chan_a_strobe,
  input wire logic                  chan_b_strobe,
  input wire logic                  range_flag_a,
  input wire logic                  range_flag_b,
  output dao_sample_t               ddr_a,
  output dao_sample_t               ddr_b,
  output dao_sample_t               par_a,
  output dao_sample_t               par_b
);
  logic ddr_q, sa_q, sb_q;
  always_ff @(posedge mclk) begin
    ddr_q <= ddr_capture_strobe;
    sa_q  <= chan_a_strobe;
    sb_q  <= chan_b_strobe;
    if (!resetn) begin
      ddr_a <= DAO_SAMPLE_RST;
      ddr_b <= DAO_SAMPLE_RST;
      par_a <= DAO_SAMPLE_RST;
      par_b <= DAO_SAMPLE_RST;
    end else begin
      // A on rise, B on fall
      if (ddr_capture_strobe && !ddr_q)
        ddr_a <= '{over: range_flag_pair, word: interleaved_bit_pairs};
      if (!ddr_capture_strobe && ddr_q)
        ddr_b <= '{over: range_flag_pair, word: interleaved_bit_pairs};
      if (chan_a_strobe && !sa_q)
        par_a <= '{over: range_flag_a, word: chan_a_word};
      if (chan_b_strobe && !sb_q)
        par_b <= '{over: range_flag_b, word: chan_b_word};
    end
  end
endmodule : dao_capture

//--- test/dao_output_asserts.sv
// Concurrent checks on the ports of the dual converter output block.
`timescale 1ns/1ps
module dao_output_asserts
  import dao_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire logic                  sleep_chan_a,
  input wire logic [1:0]            format_and_duty_select,
  input wire logic [DAO_WORD_W-1:0] interleaved_bit_pairs,
  input wire logic                  range_flag_pair,
  input wire logic                  ddr_capture_strobe,
  input wire logic [DAO_WORD_W-1:0] chan_a_word,
  input wire logic [DAO_WORD_W-1:0] chan_b_word,
  input wire logic                  chan_a_strobe,
  input wire logic                  chan_b_strobe,
  input wire logic                  range_flag_a,
  input wire logic                  range_flag_b,
  input wire logic                  duty_correction,
  input wire logic                  sleep_a_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_ddr_edge;
    $rose(ddr_capture_strobe) || $fell(ddr_capture_strobe);
  endsequence
  sequence s_par_rise;
    $rose(chan_a_strobe);
  endsequence

  property p_ddr_edge;
    s_ddr_edge |-> $stable(interleaved_bit_pairs) && $stable(range_flag_pair);
  endproperty
  property p_par_a;
    s_par_rise |-> $stable(chan_a_word) && $stable(range_flag_a);
  endproperty
  property p_par_b;
    $rose(chan_b_strobe) |-> $stable(chan_b_word) && $stable(range_flag_b);
  endproperty
  property p_twin;
    chan_a_strobe == chan_b_strobe;
  endproperty
  property p_one_style;
    $rose(ddr_capture_strobe) |-> !chan_a_strobe && chan_a_word == '0
      && chan_b_word == '0;
  endproperty
  property p_strobe_hold;
    s_par_rise |-> chan_a_strobe [*3];
  endproperty
  property p_sleep;
    $stable(sleep_chan_a) [*5] |-> sleep_a_active == sleep_chan_a;
  endproperty
  // The reset level is part of the window so a flushed flop is not judged.
  property p_band;
    $stable({format_and_duty_select, resetn}) [*5] |-> duty_correction ==
      (format_and_duty_select == DAO_BAND_TWOS_DCC ||
       format_and_duty_select == DAO_BAND_OFFS_DCC);
  endproperty

  a_ddr_edge: assert property (p_ddr_edge)
    else $error("pair data moved at a strobe edge");
  a_par_a: assert property (p_par_a)
    else $error("word A moved at its strobe rise");
  a_par_b: assert property (p_par_b)
    else $error("word B moved at its strobe rise");
  a_twin: assert property (p_twin)
    else $error("parallel strobes differ");
  a_one_style: assert property (p_one_style)
    else $error("parallel outputs active in pair style");
  a_strobe_hold: assert property (p_strobe_hold)
    else $error("strobe high too short");
  a_sleep: assert property (p_sleep)
    else $error("sleep state does not follow pin");
  a_band: assert property (p_band)
    else $error("duty correction does not match band");
endmodule : dao_output_asserts

bind dao_output dao_output_asserts chk_u (.mclk, .resetn, .sleep_chan_a,
  .format_and_duty_select, .interleaved_bit_pairs, .range_flag_pair,
  .ddr_capture_strobe, .chan_a_word, .chan_b_word, .chan_a_strobe,
  .chan_b_strobe, .range_flag_a, .range_flag_b, .duty_correction,
  .sleep_a_active);

//--- test/dual_adc_output_interface_bench.sv
// Self-checking bench for the dual converter output block.
`timescale 1ns/1ps
module dual_adc_output_interface_bench
  import dao_pkg::*;
();
  logic mclk, resetn, ce, sample_clk, sclk_run, conv_a_over, conv_b_over;
  logic sleep_chan_a, sleep_chan_b, output_style_select, bus_wr, bus_rd;
  logic [9:0] conv_a_raw, conv_b_raw, interleaved_bit_pairs;
  logic [9:0] chan_a_word, chan_b_word;
  logic [1:0] format_and_duty_select;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, d, seed;
  logic range_flag_pair, ddr_capture_strobe, chan_a_strobe, chan_b_strobe;
  logic range_flag_a, range_flag_b, duty_correction, irq, twos, dcc;
  logic sleep_a_active, sleep_b_active;
  dao_sample_t ddr_a, ddr_b, par_a, par_b, ea, eb;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int hits;

  dao_output dut_u (.mclk, .resetn, .ce, .sample_clk, .conv_a_raw,
    .conv_b_raw, .conv_a_over, .conv_b_over, .sleep_chan_a, .sleep_chan_b,
    .output_style_select, .format_and_duty_select, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata, .interleaved_bit_pairs, .range_flag_pair,
    .ddr_capture_strobe, .chan_a_word, .chan_b_word, .chan_a_strobe,
    .chan_b_strobe, .range_flag_a, .range_flag_b, .duty_correction,
    .sleep_a_active, .sleep_b_active, .irq);
  dao_capture cap_u (.mclk, .resetn, .interleaved_bit_pairs,
    .range_flag_pair, .ddr_capture_strobe, .chan_a_word, .chan_b_word,
    .chan_a_strobe, .chan_b_strobe, .range_flag_a, .range_flag_b,
    .ddr_a, .ddr_b, .par_a, .par_b);

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  function automatic dao_sample_t expect_of(input logic [9:0] raw,
    input logic ovr, input logic slp, input logic tw);
    dao_sample_t e;
    e.over = ovr & ~slp;
    e.word = slp ? 10'h000 : raw ^ {tw, 9'h000};
    return e;
  endfunction : expect_of

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // The sample clock is stopped low while static pins change.
  initial begin
    sample_clk = 1'b0;
    #3.3;
    forever begin
      #40;
      sample_clk = sclk_run & ~sample_clk;
    end
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : reg_read
  task pause;
    sclk_run <= 1'b0;
    repeat (14) @(posedge mclk);
  endtask : pause
  task run_periods(input int n);
    sclk_run <= 1'b1;
    repeat (n * 8 + 8) @(posedge mclk);
    #1;
  endtask : run_periods

  initial begin
    {resetn, sclk_run, conv_a_over, conv_b_over, bus_wr, bus_rd} = '0;
    {sleep_chan_a, sleep_chan_b, output_style_select} = '0;
    {conv_a_raw, conv_b_raw, format_and_duty_select} = '0;
    {bus_addr, bus_wdata} = '0;
    ce = 1'b1;
    seed = 32'h00004369;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    reg_read(DAO_OFF_CTRL, d);
    check(d, {31'h0, DAO_CTRL_RST});
    reg_read(DAO_OFF_IRQ_EN, d);
    check(d, {30'h0, DAO_IRQ_EN_RST});
    reg_read(8'h20, d);
    check(d, 32'h0);
    $display("Test registers done");
    for (int i = 0; i < 12; i++) begin
      seed = xorshift(seed);
      pause();
      sleep_chan_a <= seed[0] & seed[1];
      sleep_chan_b <= seed[2] & seed[3];
      output_style_select <= i[0];
      format_and_duty_select <= i[2:1];
      conv_a_raw <= (i == 8) ? 10'h3ff : (i == 9) ? 10'h000 : seed[13:4];
      conv_b_raw <= (i == 8) ? 10'h000 : (i == 9) ? 10'h3ff : seed[23:14];
      conv_a_over <= seed[24];
      conv_b_over <= seed[25];
      run_periods(4);
      twos = format_and_duty_select inside {DAO_BAND_TWOS_DCC,
        DAO_BAND_TWOS_NODCC};
      dcc = ~format_and_duty_select[0] ^ format_and_duty_select[1];
      ea = expect_of(conv_a_raw, conv_a_over, sleep_chan_a, twos);
      eb = expect_of(conv_b_raw, conv_b_over, sleep_chan_b, twos);
      check({31'h0, duty_correction}, {31'h0, dcc});
      reg_read(DAO_OFF_STATE, d);
      check(d, {25'h0, twos, dcc, format_and_duty_select,
        output_style_select, sleep_chan_b, sleep_chan_a});
      if (output_style_select) begin
        check({21'h0, ddr_a}, {21'h0, ea});
        check({21'h0, ddr_b}, {21'h0, eb});
      end else begin
        check({21'h0, par_a}, {21'h0, ea});
        check({21'h0, par_b}, {21'h0, eb});
      end
      $display("Test samples %0d done", i);
    end
    pause();
    {conv_a_over, conv_b_over, sleep_chan_a, sleep_chan_b} <= '0;
    run_periods(2);
    reg_write(DAO_OFF_IRQ_CLR, 32'h3);
    reg_read(DAO_OFF_IRQ_ST, d);
    check(d, 32'h0);
    conv_a_over <= 1'b1;
    run_periods(2);
    reg_read(DAO_OFF_IRQ_ST, d);
    check(d, 32'h1);
    check({31'h0, irq}, 32'h0);
    reg_write(DAO_OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge mclk);
    #1 check({31'h0, irq}, 32'h1);
    conv_a_over <= 1'b0;
    run_periods(2);
    reg_write(DAO_OFF_IRQ_CLR, 32'h1);
    repeat (2) @(posedge mclk);
    #1 check({31'h0, irq}, 32'h0);
    $display("Test interrupt done");
    // A low clock enable must freeze the pin synchroniser and its outputs.
    pause();
    ce <= 1'b0;
    sleep_chan_b <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 check({31'h0, sleep_b_active}, 32'h0);
    ce <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 check({31'h0, sleep_b_active}, 32'h1);
    $display("Test clock enable done");
    pause();
    reg_write(DAO_OFF_CTRL, 32'h0);
    reg_read(DAO_OFF_CTRL, d);
    check(d, 32'h0);
    sclk_run <= 1'b1;
    hits = 0;
    repeat (40) begin
      @(posedge mclk);
      #1 if (ddr_capture_strobe !== 1'b0 || chan_a_strobe !== 1'b0) hits++;
    end
    check(hits, 0);
    reg_write(DAO_OFF_CTRL, 32'h1);
    $display("Test output gate done");
    give_verdict();
  end
endmodule : dual_adc_output_interface_bench
